// >>> ppc_bank.sv
// port pad control bank with an ahb-lite register slave
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module ppc_bank (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  // device state
  input wire logic ext_reset_pin_enable,
  input wire logic debug_mode,
  // pad inputs
  input wire logic [7:0] pin_a_in,
  input wire logic [7:0] pin_b_in,
  input wire logic [7:0] pin_c_in,
  input wire logic port_e_pin3_in,
  input wire logic schmitt_input_b1,
  input wire logic schmitt_input_b2,
  input wire logic schmitt_input_c3,
  input wire logic schmitt_input_c4,
  // pad drive
  output logic [7:0] pin_a_out,
  output logic [7:0] pin_b_out,
  output logic [7:0] pin_c_out,
  output logic [7:0] pin_a_oe_n,
  output logic [7:0] pin_b_oe_n,
  output logic [7:0] pin_c_oe_n,
  // pad configuration
  output logic [7:0] pullup_enable_a,
  output logic [7:0] pullup_enable_b,
  output logic [7:0] pullup_enable_c,
  output logic pullup_e_pin3,
  output logic [7:0] analog_sel_a,
  output logic [7:0] analog_sel_b,
  output logic [7:0] analog_sel_c,
  output logic [7:0] edge_rate_select_a,
  output logic [7:0] edge_rate_select_b,
  output logic [7:0] edge_rate_select_c,
  output logic [7:0] in_level_a,
  output logic [7:0] in_level_b,
  output logic [7:0] in_level_c,
  output logic in_level_e3,
  output logic [7:0] pad_twowire_config_b1,
  output logic [7:0] pad_twowire_config_b2,
  output logic [7:0] pad_twowire_config_c3,
  output logic [7:0] pad_twowire_config_c4,
  output logic [7:0] drive_pos_a,
  output logic [7:0] drive_pos_b,
  output logic [7:0] drive_pos_c,
  output logic [7:0] drive_neg_a,
  output logic [7:0] drive_neg_b,
  output logic [7:0] drive_neg_c
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // implemented bits of each register
  function automatic logic [7:0] impl_mask(input logic [5:0] ix);
    logic [7:0] m;
    m = ppc_pkg::MASK_FULL;
    if (ix == ppc_pkg::IX_LVL_E || ix == ppc_pkg::IX_WPU_E ||
        ix == ppc_pkg::IX_INL_E) begin
      m = ppc_pkg::MASK_E3;
    end else if (ix >= ppc_pkg::IX_TW_B1 && ix <= ppc_pkg::IX_TW_C4) begin
      m = ppc_pkg::MASK_TW;
    end else if (ix > ppc_pkg::IX_LAST) begin
      m = 8'h00;
    end
    return m;
  endfunction

  // reset value of each register
  function automatic logic [7:0] rst_val(input logic [5:0] ix);
    logic [7:0] v;
    v = ppc_pkg::RST_DEF;
    if (ix >= ppc_pkg::IX_DIR_A && ix <= ppc_pkg::IX_DIR_C) begin
      v = ppc_pkg::RST_DIR;
    end else if (ix >= ppc_pkg::IX_WPU_A && ix <= ppc_pkg::IX_WPU_E) begin
      v = ppc_pkg::RST_WPU;
    end
    return v;
  endfunction

  // read path of a two-wire capable pad
  function automatic logic pad_read(input logic [7:0] cfg, input logic norm,
                                    input logic st);
    return (cfg[ppc_pkg::TW_TH_LSB +: 2] != ppc_pkg::TW_TH_NORMAL) ?
           st : norm;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [7:0] a_s1_r, a_s2_r, b_s1_r, b_s2_r, c_s1_r, c_s2_r;
  logic [4:0] x_s1_r, x_s2_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_s1_r <= 8'h00;
      a_s2_r <= 8'h00;
      b_s1_r <= 8'h00;
      b_s2_r <= 8'h00;
      c_s1_r <= 8'h00;
      c_s2_r <= 8'h00;
      x_s1_r <= 5'h00;
      x_s2_r <= 5'h00;
    end else begin
      a_s1_r <= pin_a_in;
      a_s2_r <= a_s1_r;
      b_s1_r <= pin_b_in;
      b_s2_r <= b_s1_r;
      c_s1_r <= pin_c_in;
      c_s2_r <= c_s1_r;
      x_s1_r <= {schmitt_input_c4, schmitt_input_c3, schmitt_input_b2,
                 schmitt_input_b1, port_e_pin3_in};
      x_s2_r <= x_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [7:0] regs_r [ppc_pkg::NREG];
  logic [7:0] regs_nxt [ppc_pkg::NREG];
  logic wr_pend_r;
  logic [5:0] wr_ix_r;

  wire addr_ph = hsel & hready & (htrans == ppc_pkg::HTRANS_NONSEQ);
  wire [5:0] a_ix = haddr[7:2];
  wire a_hit = (haddr[31:ppc_pkg::ADDR_HI_LSB] == 24'h000000) &
               (haddr[1:0] == 2'h0) & (a_ix <= ppc_pkg::IX_LAST);
  wire lvl_w = (wr_ix_r <= ppc_pkg::IX_LVL_C);
  wire [5:0] w_tgt = lvl_w ? 6'(wr_ix_r + ppc_pkg::LVL_TO_LAT) : wr_ix_r;
  wire w_ok = wr_pend_r & (wr_ix_r != ppc_pkg::IX_LVL_E);

  always_comb begin
    for (int i = 0; i < ppc_pkg::NREG; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    if (w_ok) begin
      regs_nxt[w_tgt] = (hwdata[7:0] & impl_mask(w_tgt)) |
                        (regs_r[w_tgt] & ~impl_mask(w_tgt));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < ppc_pkg::NREG; i++) begin
        regs_r[i] <= rst_val(6'(i));
      end
    end else begin
      for (int i = 0; i < ppc_pkg::NREG; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ix_r <= 6'h00;
    end else begin
      wr_pend_r <= addr_ph & hwrite & a_hit;
      wr_ix_r <= a_ix;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  wire [7:0] lvl_a = a_s2_r;
  wire [7:0] b_raw = {b_s2_r[7:3],
                      pad_read(regs_r[ppc_pkg::IX_TW_B2], b_s2_r[2],
                               x_s2_r[2]),
                      pad_read(regs_r[ppc_pkg::IX_TW_B1], b_s2_r[1],
                               x_s2_r[1]),
                      b_s2_r[0]};
  wire [7:0] lvl_b = debug_mode ?
                     (b_raw | (8'h01 << ppc_pkg::B6_BIT) |
                      (8'h01 << ppc_pkg::B7_BIT)) : b_raw;
  wire [7:0] lvl_c = {c_s2_r[7:5],
                      pad_read(regs_r[ppc_pkg::IX_TW_C4], c_s2_r[4],
                               x_s2_r[4]),
                      pad_read(regs_r[ppc_pkg::IX_TW_C3], c_s2_r[3],
                               x_s2_r[3]),
                      c_s2_r[2:0]};
  wire e3_lvl = ext_reset_pin_enable | x_s2_r[0];
  wire [7:0] lvl_e = {4'h0, e3_lvl, 3'h0};
  wire [7:0] reg_rd = (a_ix <= ppc_pkg::IX_LAST) ?
                      (regs_nxt[a_ix] & impl_mask(a_ix)) : 8'h00;
  wire [7:0] rd_val = !a_hit ? 8'h00 :
                      (a_ix == ppc_pkg::IX_LVL_A) ? lvl_a :
                      (a_ix == ppc_pkg::IX_LVL_B) ? lvl_b :
                      (a_ix == ppc_pkg::IX_LVL_C) ? lvl_c :
                      (a_ix == ppc_pkg::IX_LVL_E) ? lvl_e : reg_rd;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= ppc_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= ppc_pkg::HRESP_OKAY;
      if (addr_ph && !hwrite) begin
        hrdata <= {24'h000000, rd_val};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive

  wire [7:0] oen_a = regs_nxt[ppc_pkg::IX_DIR_A] |
                     (regs_nxt[ppc_pkg::IX_ODC_A] & regs_nxt[ppc_pkg::IX_LAT_A]);
  wire [7:0] oen_b = regs_nxt[ppc_pkg::IX_DIR_A + 6'h01] |
                     (regs_nxt[ppc_pkg::IX_ODC_B] & regs_nxt[ppc_pkg::IX_LAT_B]);
  wire [7:0] oen_c = regs_nxt[ppc_pkg::IX_DIR_C] |
                     (regs_nxt[ppc_pkg::IX_ODC_C] & regs_nxt[ppc_pkg::IX_LAT_C]);
  wire pu_e3 = regs_nxt[ppc_pkg::IX_WPU_E][ppc_pkg::E3_BIT] |
               ext_reset_pin_enable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_a_oe_n <= 8'hff;
      pin_b_oe_n <= 8'hff;
      pin_c_oe_n <= 8'hff;
      pullup_e_pin3 <= 1'b0;
    end else begin
      pin_a_oe_n <= oen_a;
      pin_b_oe_n <= oen_b;
      pin_c_oe_n <= oen_c;
      pullup_e_pin3 <= pu_e3;
    end
  end

  assign pin_a_out = regs_r[ppc_pkg::IX_LAT_A];
  assign pin_b_out = regs_r[ppc_pkg::IX_LAT_B];
  assign pin_c_out = regs_r[ppc_pkg::IX_LAT_C];
  assign pullup_enable_a = regs_r[ppc_pkg::IX_WPU_A];
  assign pullup_enable_b = regs_r[ppc_pkg::IX_WPU_B];
  assign pullup_enable_c = regs_r[ppc_pkg::IX_WPU_C];
  assign analog_sel_a = regs_r[ppc_pkg::IX_ANS_A];
  assign analog_sel_b = regs_r[ppc_pkg::IX_ANS_A + 6'h01];
  assign analog_sel_c = regs_r[ppc_pkg::IX_ANS_C];
  assign edge_rate_select_a = regs_r[ppc_pkg::IX_SLR_A];
  assign edge_rate_select_b = regs_r[ppc_pkg::IX_SLR_A + 6'h01];
  assign edge_rate_select_c = regs_r[ppc_pkg::IX_SLR_A + 6'h02];
  assign in_level_a = regs_r[ppc_pkg::IX_INL_A];
  assign in_level_b = regs_r[ppc_pkg::IX_INL_A + 6'h01];
  assign in_level_c = regs_r[ppc_pkg::IX_INL_A + 6'h02];
  assign in_level_e3 = regs_r[ppc_pkg::IX_INL_E][ppc_pkg::E3_BIT];
  assign pad_twowire_config_b1 = regs_r[ppc_pkg::IX_TW_B1];
  assign pad_twowire_config_b2 = regs_r[ppc_pkg::IX_TW_B2];
  assign pad_twowire_config_c3 = regs_r[ppc_pkg::IX_TW_C3];
  assign pad_twowire_config_c4 = regs_r[ppc_pkg::IX_TW_C4];
  assign drive_pos_a = regs_r[ppc_pkg::IX_CDP_A];
  assign drive_pos_b = regs_r[ppc_pkg::IX_CDP_A + 6'h01];
  assign drive_pos_c = regs_r[ppc_pkg::IX_CDP_A + 6'h02];
  assign drive_neg_a = regs_r[ppc_pkg::IX_CDN_A];
  assign drive_neg_b = regs_r[ppc_pkg::IX_CDN_A + 6'h01];
  assign drive_neg_c = regs_r[ppc_pkg::IX_CDN_A + 6'h02];

endmodule

// >>> ppc_pkg.sv
// constants for the port pad control bank
package ppc_pkg;
  // register indices, byte address is four times the index
  localparam int unsigned IDX_W = 6;
  localparam logic [5:0] IX_LVL_A = 6'h00;
  localparam logic [5:0] IX_LVL_B = 6'h01;
  localparam logic [5:0] IX_LVL_C = 6'h02;
  localparam logic [5:0] IX_LVL_E = 6'h03;
  localparam logic [5:0] IX_DIR_A = 6'h04;
  localparam logic [5:0] IX_DIR_C = 6'h06;
  localparam logic [5:0] IX_LAT_A = 6'h07;
  localparam logic [5:0] IX_LAT_B = 6'h08;
  localparam logic [5:0] IX_LAT_C = 6'h09;
  localparam logic [5:0] IX_ANS_A = 6'h0a;
  localparam logic [5:0] IX_ANS_C = 6'h0c;
  localparam logic [5:0] IX_WPU_A = 6'h0d;
  localparam logic [5:0] IX_WPU_B = 6'h0e;
  localparam logic [5:0] IX_WPU_C = 6'h0f;
  localparam logic [5:0] IX_WPU_E = 6'h10;
  localparam logic [5:0] IX_ODC_A = 6'h11;
  localparam logic [5:0] IX_ODC_B = 6'h12;
  localparam logic [5:0] IX_ODC_C = 6'h13;
  localparam logic [5:0] IX_SLR_A = 6'h14;
  localparam logic [5:0] IX_INL_A = 6'h17;
  localparam logic [5:0] IX_INL_E = 6'h1a;
  localparam logic [5:0] IX_TW_B1 = 6'h1b;
  localparam logic [5:0] IX_TW_B2 = 6'h1c;
  localparam logic [5:0] IX_TW_C3 = 6'h1d;
  localparam logic [5:0] IX_TW_C4 = 6'h1e;
  localparam logic [5:0] IX_CDP_A = 6'h1f;
  localparam logic [5:0] IX_CDN_A = 6'h22;
  localparam logic [5:0] IX_LAST = 6'h24;
  localparam int unsigned NREG = 37;
  // offset from a pin level index to its output latch index
  localparam logic [5:0] LVL_TO_LAT = 6'h07;
  // implemented bit masks
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_E3 = 8'h08;
  localparam logic [7:0] MASK_TW = 8'h73;
  // pad two-wire config fields
  localparam int unsigned TW_EDGE_RATE_SELECT_BIT = 6;
  localparam int unsigned TW_PU_LSB = 4;
  localparam int unsigned TW_TH_LSB = 0;
  localparam logic [1:0] TW_TH_NORMAL = 2'h0;
  // bit positions of special pins
  localparam int unsigned E3_BIT = 3;
  localparam int unsigned B6_BIT = 6;
  localparam int unsigned B7_BIT = 7;
  // reset values
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_DEF = 8'h00;
  localparam logic [7:0] RST_WPU = 8'h00;
  // bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam int unsigned ADDR_HI_LSB = 8;
endpackage

// >>> ppc_bank_checker.sv
// assertions for the port pad control bank
`timescale 1ns/1ps
module ppc_bank_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  // device state and pads
  input wire logic ext_reset_pin_enable,
  input wire logic debug_mode,
  input wire logic pullup_e_pin3,
  input wire logic [7:0] pullup_enable_a
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////
  wire take = hsel && hreadyout && htrans == ppc_pkg::HTRANS_NONSEQ;
  wire rd = take && !hwrite;
  wire [5:0] ix = haddr[7:2];
  wire wpa = take && hwrite && ix == ppc_pkg::IX_WPU_A && haddr[31:8] == 0;
  ready_high_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state seen");
  wpu_reset_a: assert property ($rose(hresetn) |-> !pullup_enable_a)
    else $error("pull-up not cleared by reset");
  wpu_write_a: assert property (
    wpa ##1 1'b1 |=> pullup_enable_a == $past(hwdata[7:0]))
    else $error("pull-up write not applied");
  e3_force_a: assert property (ext_reset_pin_enable |=> pullup_e_pin3)
    else $error("pin e3 pull-up not forced");
  e3_level_a: assert property (
    rd && ix == ppc_pkg::IX_LVL_E && ext_reset_pin_enable
    |=> hrdata == 32'h8) else $error("pin e3 level wrong");
  dbg_read_a: assert property (
    rd && ix == ppc_pkg::IX_LVL_B && debug_mode |=> &hrdata[7:6])
    else $error("debug pins not read as one");
  unmapped_a: assert property (
    rd && ix > ppc_pkg::IX_LAST |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  pullup_enable_e_mask_a: assert property (
    rd && ix == ppc_pkg::IX_WPU_E |=> !(hrdata & ~32'h8))
    else $error("unimplemented bits not zero");
endmodule
bind ppc_bank ppc_bank_checker chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hrdata, .hreadyout, .ext_reset_pin_enable,
  .debug_mode, .pullup_e_pin3, .pullup_enable_a);

// >>> ppc_pad_model.sv
// pad model: pin level from pad drive, pull-up and outside drive
`timescale 1ns/1ps
module ppc_pad_model (
  // clock
  input wire logic hclk,
  // bank side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pu_en,
  output logic [7:0] pad_in,
  // outside drive
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_en
);
  logic [7:0] float_r;
  //////////////////////////////////////////////////////////////////////
  // a released pin with neither pull-up nor outside drive wanders every cycle
  initial float_r = 8'h55;
  always @(posedge hclk) float_r <= ~float_r;
  assign pad_in = ~pad_oe_n & pad_out | pad_oe_n & ext_en & ext_drv
    | pad_oe_n & ~ext_en & (pu_en | float_r);
endmodule

// >>> test_ppc_bank.sv
// self-checking bench for the port pad control bank
`timescale 1ns/1ps
module test_ppc_bank;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dph = 0;
  logic ext_reset_pin_enable = 0, debug_mode = 0, port_e_pin3_in = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [3:0] st = 4'h0;
  logic [7:0] xd [3] = '{8'h0, 8'h0, 8'h0};
  logic [7:0] xe [3] = '{8'h0, 8'h0, 8'h0};
  logic hreadyout, pullup_e_pin3;
  logic [7:0] pin_a_in, pin_b_in, pin_c_in, pin_a_out, pin_b_out, pin_c_out;
  logic [7:0] pin_a_oe_n, pin_b_oe_n, pin_c_oe_n;
  logic [7:0] pullup_enable_a, pullup_enable_b, pullup_enable_c, d;
  logic [7:0] expq [$];
  int n_fail = 0, samples_checked = 0;
  //////////////////////////////////////////////////////////////////////
  ppc_bank uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp(), .ext_reset_pin_enable, .debug_mode, .pin_a_in, .pin_b_in,
    .pin_c_in, .port_e_pin3_in, .schmitt_input_b1(st[0]),
    .schmitt_input_b2(st[1]), .schmitt_input_c3(st[2]),
    .schmitt_input_c4(st[3]), .pin_a_out, .pin_b_out, .pin_c_out,
    .pin_a_oe_n, .pin_b_oe_n, .pin_c_oe_n, .pullup_enable_a,
    .pullup_enable_b, .pullup_enable_c, .pullup_e_pin3, .analog_sel_a(),
    .analog_sel_b(), .analog_sel_c(), .edge_rate_select_a(), .edge_rate_select_b(), .edge_rate_select_c(),
    .in_level_a(), .in_level_b(), .in_level_c(), .in_level_e3(),
    .pad_twowire_config_b1(), .pad_twowire_config_b2(),
    .pad_twowire_config_c3(), .pad_twowire_config_c4(), .drive_pos_a(),
    .drive_pos_b(), .drive_pos_c(), .drive_neg_a(), .drive_neg_b(),
    .drive_neg_c());
  ppc_pad_model pa (.hclk, .pad_out(pin_a_out), .pad_oe_n(pin_a_oe_n),
    .pu_en(pullup_enable_a), .pad_in(pin_a_in), .ext_drv(xd[0]),
    .ext_en(xe[0]));
  ppc_pad_model pb (.hclk, .pad_out(pin_b_out), .pad_oe_n(pin_b_oe_n),
    .pu_en(pullup_enable_b), .pad_in(pin_b_in), .ext_drv(xd[1]),
    .ext_en(xe[1]));
  ppc_pad_model pc (.hclk, .pad_out(pin_c_out), .pad_oe_n(pin_c_oe_n),
    .pu_en(pullup_enable_c), .pad_in(pin_c_in), .ext_drv(xd[2]),
    .ext_en(xe[2]));
  initial forever #2.5 hclk = ~hclk;
  //////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // wait for an edge with ready, bounded
  task automatic wt;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      end_sim;
    end
  endtask
  // one single transfer; for a read d is the expected byte
  task automatic xfer(input logic w, input logic [5:0] ix, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= ppc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, ix, 2'h0};
    if (!w)
      expq.push_back(d);
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt;
  endtask
  // read results are compared in their data phase
  always @(posedge hclk) dph <= hsel && htrans == 2'h2 && !hwrite && hreadyout;
  always @(negedge hclk) begin
    if (dph)
      chk(hrdata, {24'h0, expq.pop_front()});
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h29e335d4));
    tick(8);
    hresetn <= 1'b1;
    for (int i = 13; i < 17; i++) xfer(0, i[5:0], 8'h00);
    for (int i = 13; i < 16; i++) begin
      d = $urandom;
      xfer(1, i[5:0], d);
      xfer(0, i[5:0], d);
    end
    @(negedge hclk);
    chk({24'h0, pullup_enable_c}, {24'h0, d});
    $display("test pull-ups done");
    xfer(1, ppc_pkg::IX_WPU_E, 8'hff);
    xfer(0, ppc_pkg::IX_WPU_E, ppc_pkg::MASK_E3);
    xfer(1, ppc_pkg::IX_TW_B1, 8'hff);
    xfer(0, ppc_pkg::IX_TW_B1, ppc_pkg::MASK_TW);
    xfer(1, 6'h25, 8'hff);
    xfer(0, 6'h25, 8'h00);
    xfer(1, ppc_pkg::IX_LVL_E, 8'hff);
    xfer(0, ppc_pkg::IX_LVL_E, 8'h00);
    $display("test masks done");
    xfer(1, ppc_pkg::IX_WPU_E, 8'h00);
    ext_reset_pin_enable <= 1'b1;
    xfer(0, ppc_pkg::IX_WPU_E, 8'h00);
    xfer(0, ppc_pkg::IX_LVL_E, 8'h08);
    @(negedge hclk);
    chk({31'h0, pullup_e_pin3}, 32'h1);
    tick(1);
    ext_reset_pin_enable <= 1'b0;
    tick(2);
    @(negedge hclk);
    chk({31'h0, pullup_e_pin3}, 32'h0);
    $display("test reset pin done");
    d = $urandom;
    tick(1);
    xd[1] <= d;
    xe[1] <= 8'hff;
    st <= {3'h0, ~d[1]};
    debug_mode <= 1'b1;
    xfer(1, ppc_pkg::IX_TW_B1, 8'h01);
    xfer(1, ppc_pkg::IX_TW_B2, 8'h00);
    xfer(0, ppc_pkg::IX_LVL_B, (d | 8'hc0) ^ 8'h02);
    tick(1);
    debug_mode <= 1'b0;
    xfer(1, ppc_pkg::IX_TW_B1, 8'h00);
    xfer(0, ppc_pkg::IX_LVL_B, d);
    $display("test pin read done");
    d = $urandom;
    xfer(1, ppc_pkg::IX_DIR_A, 8'h00);
    xfer(1, ppc_pkg::IX_LVL_A, d);
    @(negedge hclk);
    chk({24'h0, pin_a_out}, {24'h0, d});
    chk({24'h0, pin_a_oe_n}, 32'h0);
    tick(3);
    xfer(0, ppc_pkg::IX_LVL_A, d);
    tick(1);
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    xfer(0, ppc_pkg::IX_WPU_A, 8'h00);
    $display("test drive and reset done");
    tick(3);
    end_sim;
  end
endmodule
